//--- pkg/sdc_regs.svh
// constants of the conversion and calibration sequencer
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// decimation ratios, rate family 0
`define SDC_DEC_F0_R0 9'h187
`define SDC_DEC_F0_R1 9'h139
`define SDC_DEC_F0_R2 9'h04E
`define SDC_DEC_F0_R3 9'h027
// decimation ratios, rate family 1
`define SDC_DEC_F1_R0 9'h180
`define SDC_DEC_F1_R1 9'h140
`define SDC_DEC_F1_R2 9'h04D
`define SDC_DEC_F1_R3 9'h026

// word period is this many input clocks per decimation step
`define SDC_MOD_CLOCKS 8'h80
`define SDC_MOD_SHIFT 7
// pipeline delay and overrun gap, in input clocks
`define SDC_PIPE_CLOCKS 11'h7D0
`define SDC_GAP_CLOCKS 9'h1F4

// output word periods per phase
`define SDC_NORMAL_PERIODS 4'h3
`define SDC_SELF_HALF_PERIODS 4'h3
`define SDC_SELF_CONV_PERIODS 4'h3
`define SDC_SYS_CAL_PERIODS 4'h3
`define SDC_SYS_CONV_PERIODS 4'h1

// calibration mode encodings {hi, lo}
`define SDC_MODE_NORMAL 2'h0
`define SDC_MODE_SELF 2'h1
`define SDC_MODE_SYS_ZERO 2'h2
`define SDC_MODE_SYS_FULL 2'h3

// reset values
`define SDC_CLOCK_RESET 4'h9
`define SDC_SETUP_RESET 3'h1
`define SDC_COMM_RESET 6'h00

`endif

//--- pkg/sdc_pkg.sv
// types shared by the conversion and calibration sequencer
package sdc_pkg;
    typedef struct packed {
        logic rate_family;
        logic input_clock_halver;
        logic filter_rate_hi;
        logic filter_rate_lo;
    } sdc_clock_t;

    typedef struct packed {
        logic cal_mode_hi;
        logic cal_mode_lo;
        logic filter_sync_hold;
    } sdc_setup_t;

    typedef struct packed {
        logic [1:0] channel;
        logic read_not_write;
        logic power_down_bit;
        logic [1:0] target;
    } sdc_comm_t;

    typedef enum logic [2:0] {
        ST_HOLD, ST_SELF_ZERO, ST_SELF_FULL, ST_SYS_CAL, ST_CONV, ST_PIPE, ST_RUN
    } sdc_state_t;
endpackage

//--- src/sdc_rate_divider.sv
// enable-pulse divider with restart
`timescale 1ns/1ps
`default_nettype none
module sdc_rate_divider #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_en,
    input wire logic i_restart,
    input wire logic [W-1:0] i_period,
    // tick
    output logic o_tick
);
    logic [W-1:0] count;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (i_restart) begin
            count <= '0;
            o_tick <= 1'b0;
        end else if (i_en) begin
            o_tick <= (count >= i_period - W'(1));
            count <= (count >= i_period - W'(1)) ? '0 : count + W'(1);
        end else begin
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- src/sdc_coef_store.sv
// per-channel offset and gain coefficient storage
`timescale 1ns/1ps
`default_nettype none
module sdc_coef_store (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // write side
    input wire logic i_wr_offset,
    input wire logic i_wr_gain,
    input wire logic [1:0] i_wr_channel,
    input wire logic [23:0] i_wdata,
    // read side
    input wire logic [1:0] i_rd_channel,
    output logic [23:0] o_offset,
    output logic [23:0] o_gain
);
    logic [23:0] offset_mem [4];
    logic [23:0] gain_mem [4];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 4; i++) begin
                offset_mem[i] <= 24'h000000;
                gain_mem[i] <= 24'h000000;
            end
        end else begin
            if (i_wr_offset) begin
                offset_mem[i_wr_channel] <= i_wdata;
            end
            if (i_wr_gain) begin
                gain_mem[i_wr_channel] <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_offset <= 24'h000000;
            o_gain <= 24'h000000;
        end else begin
            o_offset <= offset_mem[i_rd_channel];
            o_gain <= gain_mem[i_rd_channel];
        end
    end
endmodule
`default_nettype wire

//--- src/sdc_sequencer.sv
// conversion and calibration sequencer of a sigma-delta converter
//
// What this block does
// - decimation ratio follows rate-family and filter-rate bits per fixed table
// - word period is 128 times decimation input clocks, doubled when halved
// - after reset wait for a communications write that sets channel, direction, target
// - hold bit high keeps filter reset and stops calibration and conversion
// - hold bit low gives continuous conversions, one result per word period
// - normal mode: ready falls three word periods after hold clears
// - ready returns high when a result read completes
// - unread result overrun: ready high 500 input clocks, then low again
// - hold set while ready low keeps ready low until read or restart
// - result word stays readable repeatedly while the next conversion runs
// - ready shown both as status bit and pin, low meaning valid
// - first result after calibration waits an extra 2000 input clocks
// - self-calibration: ready falls nine word periods plus pipeline delay after start
// - system calibration: ready falls four word periods plus pipeline delay
// - mode bits clear after six periods self, three periods system calibration
// - mode bits: 01 self, 10 system zero, 11 system full, 00 normal
// - self-calibration shorts inputs for zero, then applies reference for full scale
// - coefficients land in the calibrated channel's own offset and gain pair
// - after self-calibration one three-period conversion precedes new data
// - ready rises at calibration start, within one 128-clock modulator cycle
// - reset pin low holds ready high; afterwards wait for communications write
`timescale 1ns/1ps
`default_nettype none
`include "sdc_regs.svh"
module sdc_sequencer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // host register accesses
    input wire logic i_comm_write,
    input wire sdc_pkg::sdc_comm_t i_comm,
    input wire logic i_access_done,
    input wire logic i_setup_write,
    input wire sdc_pkg::sdc_setup_t i_setup,
    input wire logic i_clock_write,
    input wire sdc_pkg::sdc_clock_t i_clock,
    input wire logic i_result_read_done,
    input wire logic i_coef_write,
    input wire logic i_coef_is_gain,
    input wire logic [23:0] i_coef_wdata,
    // filter and calibration engine
    input wire logic [15:0] i_conv_word,
    input wire logic [23:0] i_cal_coef,
    // status and results
    output logic o_result_ready_n,
    output logic o_status_ready_n,
    output logic [15:0] o_result,
    output logic o_result_update,
    output logic o_wait_comm,
    output sdc_pkg::sdc_comm_t o_comm,
    output sdc_pkg::sdc_setup_t o_setup,
    output logic [8:0] o_decimation,
    // analog front end control
    output logic o_filter_reset,
    output logic o_short_inputs,
    output logic o_apply_ref,
    output logic [23:0] o_offset,
    output logic [23:0] o_gain
);
    import sdc_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sdc_clock_t clock_reg;
    sdc_state_t state;
    logic [3:0] period_cnt;
    logic [3:0] conv_len;
    logic conv_pipe;
    logic [10:0] pipe_cnt;
    logic [8:0] gap_cnt;
    logic gap_active;
    logic raise_pend;
    logic clk_en;
    logic mod_tick;
    logic word_tick;
    logic start;
    logic restart_word;
    logic new_result;
    logic cal_done;
    logic cap_offset;
    logic cap_gain;
    logic [1:0] mode;
    logic [1:0] next_mode;

    assign mode = {o_setup.cal_mode_hi, o_setup.cal_mode_lo};
    assign next_mode = {i_setup.cal_mode_hi, i_setup.cal_mode_lo};
    // a start is the hold bit falling, or a calibration command while already released
    assign start = i_setup_write && !i_setup.filter_sync_hold
        && (o_setup.filter_sync_hold || next_mode != `SDC_MODE_NORMAL);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wait_comm <= 1'b1;
            o_comm <= `SDC_COMM_RESET;
        end else if (i_comm_write) begin
            o_wait_comm <= 1'b0;
            o_comm <= i_comm;
        end else if (i_access_done) begin
            o_wait_comm <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clock_reg <= `SDC_CLOCK_RESET;
        end else if (i_clock_write) begin
            clock_reg <= i_clock;
        end
    end

    // mode bits clear on completion; a host write in the same cycle wins
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_setup <= `SDC_SETUP_RESET;
        end else if (i_setup_write) begin
            o_setup <= i_setup;
        end else if (cal_done) begin
            o_setup.cal_mode_hi <= 1'b0;
            o_setup.cal_mode_lo <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_decimation <= `SDC_DEC_F1_R1;
        end else begin
            case ({clock_reg.rate_family, clock_reg.filter_rate_hi, clock_reg.filter_rate_lo})
                3'h0: o_decimation <= `SDC_DEC_F0_R0;
                3'h1: o_decimation <= `SDC_DEC_F0_R1;
                3'h2: o_decimation <= `SDC_DEC_F0_R2;
                3'h3: o_decimation <= `SDC_DEC_F0_R3;
                3'h4: o_decimation <= `SDC_DEC_F1_R0;
                3'h5: o_decimation <= `SDC_DEC_F1_R1;
                3'h6: o_decimation <= `SDC_DEC_F1_R2;
                default: o_decimation <= `SDC_DEC_F1_R3;
            endcase
        end
    end

    // halver enable feeds every timing counter
    sdc_rate_divider #(.W(2)) u_halver (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_en(1'b1),
        .i_restart(1'b0),
        .i_period(clock_reg.input_clock_halver ? 2'h2 : 2'h1),
        .o_tick(clk_en)
    );

    sdc_rate_divider #(.W(8)) u_modulator (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_en(clk_en),
        .i_restart(1'b0),
        .i_period(`SDC_MOD_CLOCKS),
        .o_tick(mod_tick)
    );

    // word period is decimation times 128 halved-clock ticks
    sdc_rate_divider #(.W(16)) u_word (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_en(clk_en),
        .i_restart(restart_word),
        .i_period({o_decimation, 7'h00}),
        .o_tick(word_tick)
    );

    assign restart_word = start || o_setup.filter_sync_hold
        || (state == ST_PIPE && clk_en && pipe_cnt == `SDC_PIPE_CLOCKS - 11'h001);

    always_comb begin
        new_result = 1'b0;
        cal_done = 1'b0;
        cap_offset = 1'b0;
        cap_gain = 1'b0;
        case (state)
            ST_SELF_ZERO: cap_offset = word_tick && period_cnt == `SDC_SELF_HALF_PERIODS - 4'h1;
            ST_SELF_FULL: begin
                cap_gain = word_tick && period_cnt == `SDC_SELF_HALF_PERIODS - 4'h1;
                cal_done = cap_gain;
            end
            ST_SYS_CAL: begin
                cal_done = word_tick && period_cnt == `SDC_SYS_CAL_PERIODS - 4'h1;
                cap_offset = cal_done && mode == `SDC_MODE_SYS_ZERO;
                cap_gain = cal_done && mode == `SDC_MODE_SYS_FULL;
            end
            ST_CONV: new_result = word_tick && period_cnt == conv_len - 4'h1 && !conv_pipe;
            ST_PIPE: new_result = clk_en && pipe_cnt == `SDC_PIPE_CLOCKS - 11'h001;
            ST_RUN: new_result = word_tick;
            default: new_result = 1'b0;
        endcase
        if (o_setup.filter_sync_hold || start) begin
            new_result = 1'b0;
            cal_done = 1'b0;
            cap_offset = 1'b0;
            cap_gain = 1'b0;
        end
    end

    // hold parks; mode picks path; normal start converts three periods
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_HOLD;
            period_cnt <= 4'h0;
            conv_len <= `SDC_NORMAL_PERIODS;
            conv_pipe <= 1'b0;
            pipe_cnt <= 11'h000;
        end else if (start) begin
            period_cnt <= 4'h0;
            pipe_cnt <= 11'h000;
            conv_len <= `SDC_NORMAL_PERIODS;
            conv_pipe <= 1'b0;
            case (next_mode)
                `SDC_MODE_SELF: state <= ST_SELF_ZERO;
                `SDC_MODE_SYS_ZERO, `SDC_MODE_SYS_FULL: state <= ST_SYS_CAL;
                default: state <= ST_CONV;
            endcase
        end else if (o_setup.filter_sync_hold) begin
            state <= ST_HOLD;
            period_cnt <= 4'h0;
        end else begin
            case (state)
                ST_SELF_ZERO: begin
                    period_cnt <= cap_offset ? 4'h0 : period_cnt + 4'(word_tick);
                    if (cap_offset) begin
                        state <= ST_SELF_FULL;
                    end
                end
                // conversion of three or one periods, then pipeline delay
                ST_SELF_FULL, ST_SYS_CAL: begin
                    period_cnt <= cal_done ? 4'h0 : period_cnt + 4'(word_tick);
                    if (cal_done) begin
                        state <= ST_CONV;
                        conv_pipe <= 1'b1;
                        conv_len <= (state == ST_SELF_FULL) ? `SDC_SELF_CONV_PERIODS
                                                              : `SDC_SYS_CONV_PERIODS;
                    end
                end
                ST_CONV: begin
                    period_cnt <= period_cnt + 4'(word_tick);
                    if (word_tick && period_cnt == conv_len - 4'h1) begin
                        state <= conv_pipe ? ST_PIPE : ST_RUN;
                        pipe_cnt <= 11'h000;
                    end
                end
                ST_PIPE: begin
                    pipe_cnt <= pipe_cnt + 11'(clk_en);
                    if (new_result) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: state <= ST_RUN;
                default: state <= ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_filter_reset <= 1'b1;
            o_short_inputs <= 1'b0;
            o_apply_ref <= 1'b0;
        end else begin
            o_filter_reset <= o_setup.filter_sync_hold;
            // zero phase shorts inputs, full phase applies reference
            o_short_inputs <= state == ST_SELF_ZERO && !o_setup.filter_sync_hold;
            o_apply_ref <= state == ST_SELF_FULL && !o_setup.filter_sync_hold;
        end
    end

    // the word only changes when a new result lands
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_result <= 16'h0000;
            o_result_update <= 1'b0;
        end else begin
            o_result_update <= new_result;
            if (new_result) begin
                o_result <= i_conv_word;
            end
        end
    end

    // coefficients go to the selected channel's pair
    sdc_coef_store u_coefs (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_wr_offset(cap_offset || (i_coef_write && !i_coef_is_gain)),
        .i_wr_gain(cap_gain || (i_coef_write && i_coef_is_gain)),
        .i_wr_channel(o_comm.channel),
        .i_wdata((cap_offset || cap_gain) ? i_cal_coef : i_coef_wdata),
        .i_rd_channel(o_comm.channel),
        .o_offset(o_offset),
        .o_gain(o_gain)
    );

    // ready pin and status bit; the async reset pin holds both high
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_result_ready_n <= 1'b1;
            o_status_ready_n <= 1'b1;
            gap_active <= 1'b0;
            gap_cnt <= 9'h000;
            raise_pend <= 1'b0;
        end else if (new_result) begin
            // overrun: high for a gap, then low; a read in this cycle clears the overrun
            gap_active <= !o_result_ready_n && !i_result_read_done;
            gap_cnt <= `SDC_GAP_CLOCKS;
            o_result_ready_n <= !o_result_ready_n && !i_result_read_done;
            o_status_ready_n <= !o_result_ready_n && !i_result_read_done;
            raise_pend <= 1'b0;
        end else if (start) begin
            // rise waits for the next modulator cycle
            raise_pend <= 1'b1;
            gap_active <= 1'b0;
        end else if (raise_pend && mod_tick) begin
            raise_pend <= 1'b0;
            o_result_ready_n <= 1'b1;
            o_status_ready_n <= 1'b1;
        end else if (gap_active) begin
            if (clk_en) begin
                gap_cnt <= gap_cnt - 9'h001;
            end
            if (clk_en && gap_cnt == 9'h001) begin
                gap_active <= 1'b0;
                o_result_ready_n <= 1'b0;
                o_status_ready_n <= 1'b0;
            end
        end else if (i_result_read_done) begin
            // read completes; otherwise the flag is left alone
            o_result_ready_n <= 1'b1;
            o_status_ready_n <= 1'b1;
        end
    end

    sequence read_alone_s;
        i_result_read_done && !new_result && !start && !gap_active && !raise_pend;
    endsequence

    sequence overrun_s;
        new_result && !o_result_ready_n && !i_result_read_done;
    endsequence

    hold_reset_a: assert property (o_setup.filter_sync_hold |=> o_filter_reset [*1] ##0 !new_result)
        else $error("filter not held while hold bit set");
    dec_table_a: assert property (clock_reg == 4'h0 |=> o_decimation == 9'h187)
        else $error("wrong decimation for family 0 rate 0");
    read_high_a: assert property (read_alone_s |=> o_result_ready_n)
        else $error("ready not high after read");
    pin_status_a: assert property (o_result_ready_n == o_status_ready_n)
        else $error("status bit and pin differ");
    overrun_gap_a: assert property (overrun_s |=> o_result_ready_n [*8])
        else $error("overrun gap too short");
    mode_clear_a: assert property (cal_done && !i_setup_write |=> mode == 2'h0)
        else $error("mode bits not cleared");
    comm_wait_a: assert property (i_comm_write |=> !o_wait_comm && o_comm == $past(i_comm))
        else $error("communications write not taken");
    hold_low_a: assert property (o_setup.filter_sync_hold && !o_result_ready_n
        && !i_result_read_done && !start |=> !o_result_ready_n)
        else $error("ready rose while held unread");
    self_phase_a: assert property (state == ST_SELF_ZERO && !o_setup.filter_sync_hold
        && !start |=> o_short_inputs)
        else $error("inputs not shorted in zero phase");
    start_raise_a: assert property (start && !new_result |-> ##[1:260] o_result_ready_n)
        else $error("ready did not rise after start");
endmodule
`default_nettype wire

//--- bench/sdc_host_model.sv
// host model issuing register accesses to the sequencer
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model (
    // clock
    input wire logic i_clk,
    // register accesses
    output logic o_comm_write,
    output sdc_pkg::sdc_comm_t o_comm,
    output logic o_access_done,
    output logic o_setup_write,
    output sdc_pkg::sdc_setup_t o_setup,
    output logic o_clock_write,
    output sdc_pkg::sdc_clock_t o_clock,
    output logic o_read_done
);
    import sdc_pkg::*;
    logic [1:0] chan = 2'h1;

    initial begin
        o_comm_write = 1'b0;
        o_comm = 6'h00;
        o_access_done = 1'b0;
        o_setup_write = 1'b0;
        o_setup = 3'h1;
        o_clock_write = 1'b0;
        o_clock = 4'h9;
        o_read_done = 1'b0;
    end

    task automatic access(input logic [1:0] tgt, input sdc_setup_t s, input sdc_clock_t c);
        @(posedge i_clk);
        o_comm_write <= 1'b1;
        o_comm <= {chan, tgt == 2'h3, 1'b0, tgt};
        @(posedge i_clk);
        o_comm_write <= 1'b0;
        o_setup <= s;
        o_clock <= c;
        o_setup_write <= tgt == 2'h1;
        o_clock_write <= tgt == 2'h2;
        o_read_done <= tgt == 2'h3;
        o_access_done <= 1'b1;
        @(posedge i_clk);
        o_setup_write <= 1'b0;
        o_clock_write <= 1'b0;
        o_read_done <= 1'b0;
        o_access_done <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- bench/conversion_calibration_sequencer_tb.sv
// self-checking bench for the conversion and calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module conversion_calibration_sequencer_tb;
    import sdc_pkg::*;
    // fastest rate keeps the long calibrations inside the run budget
    localparam int PER = 128 * 38;
    localparam int PIPE = 2000;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [15:0] i_conv_word = 16'h0000;
    logic [23:0] i_cal_coef = 24'h000000;
    logic i_comm_write, i_access_done, i_setup_write, i_clock_write, i_result_read_done;
    sdc_comm_t i_comm, o_comm;
    sdc_setup_t i_setup, o_setup;
    sdc_clock_t i_clock;
    logic o_result_ready_n, o_status_ready_n, o_result_update, o_wait_comm;
    logic o_filter_reset, o_short_inputs, o_apply_ref;
    logic [15:0] o_result;
    logic [8:0] o_decimation;
    logic [23:0] o_offset, o_gain;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t_clr = 0;
    int t0 = 0;
    logic [3:0] cfg [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
    logic [8:0] dec [8] = '{9'h187, 9'h139, 9'h04E, 9'h027, 9'h180, 9'h140, 9'h04D, 9'h026};

    always #25 i_clk = ~i_clk;

    // cycle stamp, and the cycle at which the mode bits went back to zero
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_setup[2:1] != 2'h0) t_clr <= cyc + 1;
    end

    sdc_host_model sdc_host_model_i (.i_clk, .o_comm_write(i_comm_write), .o_comm(i_comm),
        .o_access_done(i_access_done), .o_setup_write(i_setup_write), .o_setup(i_setup),
        .o_clock_write(i_clock_write), .o_clock(i_clock), .o_read_done(i_result_read_done));

    sdc_sequencer sdc_sequencer_i (.i_clk, .i_reset_n, .i_comm_write, .i_comm, .i_access_done,
        .i_setup_write, .i_setup, .i_clock_write, .i_clock, .i_result_read_done,
        .i_coef_write(1'b0), .i_coef_is_gain(1'b0), .i_coef_wdata(24'h000000),
        .i_conv_word, .i_cal_coef, .o_result_ready_n, .o_status_ready_n, .o_result,
        .o_result_update, .o_wait_comm, .o_comm, .o_setup, .o_decimation, .o_filter_reset,
        .o_short_inputs, .o_apply_ref, .o_offset, .o_gain);

    task automatic complete_run;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (exp !== got) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // a few cycles of slack for pulse alignment inside the design
    task automatic near(input string name, input int exp, input int got);
        check(name, 32'(exp), (got > exp - 5 && got < exp + 5) ? 32'(exp) : 32'(got));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wr(input logic [1:0] g, input logic [2:0] s);
        sdc_host_model_i.access(g, s, 4'hB);
    endtask

    // bounded wait for the ready pin, then its moment compared
    task automatic expect_at(input string name, input logic lvl, input int tgt);
        while (o_result_ready_n !== lvl && cyc - t0 < tgt + 9) tick(1);
        near(name, tgt, cyc - t0);
        if (o_result_ready_n !== lvl) complete_run();
    endtask

    task automatic start_cal(input logic [1:0] md);
        wr(2'h1, {md, 1'b0});
        t0 = cyc;
        while (o_result_ready_n !== 1'b1 && cyc - t0 < 140) tick(1);
        check("ready rise", 1, o_result_ready_n === 1'b1 && cyc - t0 < 133);
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        check("ready pin", 1, o_result_ready_n);
        check("status bit", 1, o_status_ready_n);
        check("wait comm", 1, o_wait_comm);
        check("setup", 3'h1, o_setup);
        // look between the comm write and the end of the access
        fork
            wr(2'h0, 3'h1);
            begin
                tick(2);
                check("wait comm", 0, o_wait_comm);
                check("comm reg", 6'h10, o_comm);
            end
        join
        tick(1);
        check("wait again", 1, o_wait_comm);
        for (int k = 0; k < 8; k++) begin
            sdc_host_model_i.access(2'h2, 3'h1, cfg[k]);
            tick(2);
            check("decimation", dec[k], o_decimation);
        end
        for (int k = 3; k >= 0; k--) begin
            wr(2'h1, {2'(k), 1'b1});
            tick(2);
            check("mode bits", {2'(k), 1'b1}, o_setup);
            check("filter held", 1, o_filter_reset);
            check("no result", 1, o_result_ready_n);
        end
        i_conv_word <= 16'hA5C3;
        start_cal(2'h0);
        expect_at("normal fall", 0, 3 * PER);
        check("update pulse", 1, o_result_update);
        check("status bit", 0, o_status_ready_n);
        check("filter run", 0, o_filter_reset);
        wr(2'h3, 3'h0);
        tick(2);
        check("ready after read", 1, o_result_ready_n);
        wr(2'h3, 3'h0);
        tick(1);
        check("reread", 16'hA5C3, o_result);
        expect_at("next result", 0, 4 * PER);
        i_conv_word <= 16'h5A3C;
        expect_at("overrun rise", 1, 5 * PER + 1);
        t0 = cyc;
        expect_at("overrun gap", 0, 500);
        check("no update", 0, o_result_update);
        check("new word", 16'h5A3C, o_result);
        wr(2'h1, 3'h1);
        tick(300);
        check("ready held", 0, o_result_ready_n);
        wr(2'h3, 3'h1);
        tick(2);
        check("ready after read", 1, o_result_ready_n);
        sdc_host_model_i.chan = 2'h0;
        i_cal_coef <= 24'h0D0E0F;
        start_cal(2'h2);
        expect_at("system fall", 0, 4 * PER + PIPE);
        near("system clear", 3 * PER, t_clr - t0);
        check("offset ch0", 24'h0D0E0F, o_offset);
        sdc_host_model_i.chan = 2'h1;
        i_cal_coef <= 24'h0A0B0C;
        start_cal(2'h1);
        tick(PER - (cyc - t0));
        check("short zero", 2'h2, {o_short_inputs, o_apply_ref});
        tick(4 * PER - (cyc - t0));
        check("apply ref", 2'h1, {o_short_inputs, o_apply_ref});
        @(posedge i_clk) i_cal_coef <= 24'h0C0FFE;
        expect_at("self fall", 0, 9 * PER + PIPE);
        near("self clear", 6 * PER, t_clr - t0);
        check("offset ch1", 24'h0A0B0C, o_offset);
        check("gain ch1", 24'h0C0FFE, o_gain);
        sdc_host_model_i.chan = 2'h0;
        wr(2'h0, 3'h0);
        tick(3);
        check("offset ch0", 24'h0D0E0F, o_offset);
        check("gain ch0", 24'h000000, o_gain);
        i_reset_n <= 1'b0;
        tick(2);
        check("reset ready", 1, o_result_ready_n);
        check("reset wait", 1, o_wait_comm);
        complete_run();
    end
endmodule
`default_nettype wire
